// ==== hw/lowpower_ctrl.sv ====
// low-power mode controller with break and reset cause status
`include "lowpower_defs.svh"

// Operation
// - wait or stop execution clears the interrupt mask bit.
// - wait mode stops cpu clocks, peripheral clocks keep running.
// - wait wake by interrupt starts stacking one cycle later.
// - reset or break also ends wait mode.
// - exit request is reset pin OR interrupt OR break.
// - watchdog enabled and running in wait when disable bit is 0.
// - stop entry clears the counter and disables clock generator output.
// - interrupt, reset or break ends stop mode.
// - after stop wake, stacking waits for the full recovery delay.
// - recovery is 4096 oscillator cycles, or 32 with short recovery.
// - counter held clear in stop, then times the recovery.
// - break ending wait or stop sets the break exit flag.
// - writing 0 or any reset clears the break exit flag.
// - reading the reset cause register clears all its flags.
// - power-on sets its flag and clears all other cause flags.
// - pin, watchdog, bad opcode, low voltage each set own flag.
// - bad address flag only for opcode fetches, not data accesses.
// - monitor flag on entry with erased vector and ext_interrupt_pin_one at supply.
// - status clears during break allowed only with clear enable set; the break exit flag write clear is not gated.
// - flags cleared in break stay cleared; two-step clears finish after.
module lowpower_ctrl
    import lowpower_pkg::*;
#(
    parameter int          CNT_W          = `RECOVERY_CNT_W,
    parameter logic [12:0] LONG_RECOVERY  = 13'(`LONG_RECOVERY_CYCLES),
    parameter logic [12:0] SHORT_RECOVERY = 13'(`SHORT_RECOVERY_CYCLES)
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       osc_tick_i,
    input  wire logic       wait_exec_i,
    input  wire logic       stop_exec_i,
    input  wire logic       irq_req_i,
    input  wire logic       break_irq_i,
    input  wire logic       break_state_i,
    input  wire logic       ext_rst_pin_i,
    input  wire logic       watchdog_disable_i,
    input  wire logic       short_stop_recovery_i,
    input  wire reset_src_t reset_src_i,
    input  wire reg_req_t   reg_req_i,
    output logic [7:0]      rdata_o,
    output logic            clear_imask_o,
    output logic            cpu_clk_en_o,
    output logic            periph_clk_en_o,
    output logic            clock_gen_output_o,
    output logic            stack_start_o,
    output logic            lowpower_exit_request_o,
    output logic            watchdog_run_o,
    output logic            status_clear_allow_o
);
    lp_state_t  state_reg;
    lp_state_t  state_next;
    logic       irq_wake_reg;
    logic       break_wake_reg;
    logic [7:0] reset_cause_reg;
    logic [7:0] reset_cause_next;
    logic [7:0] break_status_reg;
    logic [7:0] break_status_next;
    logic [7:0] break_flag_ctrl_reg;
    logic [7:0] rdata_next;
    logic       clear_imask_reg;
    logic       cpu_clk_en_reg;
    logic       periph_clk_en_reg;
    logic       clk_gen_reg;
    logic       stack_reg;
    logic       exit_req_reg;
    logic       wdog_run_reg;
    logic       clear_allow_reg;
    logic       clear_imask_next;
    logic       cpu_clk_en_next;
    logic       periph_clk_en_next;
    logic       clk_gen_next;
    logic       stack_next;
    logic       wdog_run_next;
    logic       irq_wake_next;
    logic       break_wake_next;
    logic [7:0] break_flag_ctrl_next;

    // bus decode
    wire sel_status = (reg_req_i.addr == `BREAK_STATUS_ADDR);
    wire sel_cause  = (reg_req_i.addr == `RESET_CAUSE_ADDR);
    wire sel_ctrl   = (reg_req_i.addr == `BREAK_FLAG_CTRL_ADDR);
    wire rd_cause   = reg_req_i.rd && sel_cause;
    wire wr_status  = reg_req_i.wr && sel_status;
    wire wr_ctrl    = reg_req_i.wr && sel_ctrl;

    wire break_clear_enable = break_flag_ctrl_reg[`BREAK_CLEAR_EN_BIT];
    // protected flags keep their value through break
    wire clear_allowed = !break_state_i || break_clear_enable;

    wire exit_request = ext_rst_pin_i || irq_req_i || break_irq_i;

    wire in_wait     = (state_reg == ST_WAIT);
    wire in_stop     = (state_reg == ST_STOP);
    wire in_recover  = (state_reg == ST_RECOVER);
    wire wait_exit   = in_wait && exit_request;
    wire stop_exit   = in_stop && exit_request;
    wire break_exit  = (in_wait || in_stop) && break_irq_i;
    wire recover_done;

    // counter cleared throughout stop, runs only in recovery
    wire counter_clear = !in_recover;
    wire [CNT_W-1:0] recovery_limit = short_stop_recovery_i
        ? CNT_W'(SHORT_RECOVERY) : CNT_W'(LONG_RECOVERY);

    recovery_counter #(
        .W (CNT_W)
    ) u_recovery (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .clear_i (counter_clear),
        .tick_i  (osc_tick_i),
        .limit_i (recovery_limit),
        .done_o  (recover_done)
    );

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (stop_exec_i) begin
                    state_next = ST_STOP;
                end else if (wait_exec_i) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (exit_request) begin
                    state_next = ST_RUN;
                end
            end
            ST_STOP: begin
                if (exit_request) begin
                    state_next = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (recover_done) begin
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    // reset cause: set wins over read clear, power-on wipes the rest
    always_comb begin
        reset_cause_next = reset_cause_reg;
        if (rd_cause && clear_allowed) begin
            reset_cause_next = 8'h00;
        end
        if (reset_src_i.ext_pin) begin
            reset_cause_next[`CAUSE_PIN_BIT] = 1'b1;
        end
        if (reset_src_i.watchdog) begin
            reset_cause_next[`CAUSE_WDOG_BIT] = 1'b1;
        end
        if (reset_src_i.bad_opcode) begin
            reset_cause_next[`CAUSE_OPCODE_BIT] = 1'b1;
        end
        if (reset_src_i.bad_address && reset_src_i.opcode_fetch) begin
            reset_cause_next[`CAUSE_ADDR_BIT] = 1'b1;
        end
        if (reset_src_i.monitor_entry && reset_src_i.vector_erased
            && reset_src_i.ext_interrupt_pin_one_at_supply) begin
            reset_cause_next[`CAUSE_MONITOR_BIT] = 1'b1;
        end
        if (reset_src_i.low_voltage) begin
            reset_cause_next[`CAUSE_LVI_BIT] = 1'b1;
        end
        if (reset_src_i.power_on) begin
            reset_cause_next = `RESET_CAUSE_RESET;
        end
    end

    // break exit flag: only the flag bit is writable, and only to 0
    always_comb begin
        break_status_next = break_status_reg;
        if (wr_status && !reg_req_i.wdata[`BREAK_EXIT_BIT]) begin
            break_status_next[`BREAK_EXIT_BIT] = 1'b0;
        end
        if (break_exit) begin
            break_status_next[`BREAK_EXIT_BIT] = 1'b1;
        end
    end

    // unmapped addresses read as zero
    assign rdata_next = !reg_req_i.rd ? rdata_o :
                        sel_status ? break_status_reg :
                        sel_cause  ? reset_cause_reg :
                        sel_ctrl   ? break_flag_ctrl_reg : 8'h00;

    // wake source is latched once, at the stop exit edge
    assign irq_wake_next   = stop_exit ? irq_req_i : irq_wake_reg;
    assign break_wake_next = stop_exit ? break_irq_i : break_wake_reg;

    // only the clear enable bit is kept, the others read 0
    assign break_flag_ctrl_next = wr_ctrl
        ? (reg_req_i.wdata & (8'h01 << `BREAK_CLEAR_EN_BIT))
        : break_flag_ctrl_reg;

    wire next_run      = (state_next == ST_RUN);
    wire next_wait     = (state_next == ST_WAIT);
    wire next_clk_off  = (state_next == ST_STOP)
                         || (state_next == ST_RECOVER);
    wire wait_irq_wake = wait_exit && irq_req_i && !break_irq_i;
    // break wins over irq, it is served through its own vector
    wire stop_irq_wake = in_recover && recover_done && irq_wake_reg
                         && !break_wake_reg;

    assign clear_imask_next   = (state_reg == ST_RUN)
                                && (wait_exec_i || stop_exec_i);
    assign cpu_clk_en_next    = next_run;
    assign periph_clk_en_next = next_run || next_wait;
    // clock generator stays off until recovery is counted out
    assign clk_gen_next       = !next_clk_off;
    assign stack_next         = wait_irq_wake || stop_irq_wake;
    assign wdog_run_next      = !watchdog_disable_i
                                && !next_clk_off;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg      <= ST_RUN;
            irq_wake_reg   <= 1'b0;
            break_wake_reg <= 1'b0;
        end else begin
            state_reg      <= state_next;
            irq_wake_reg   <= irq_wake_next;
            break_wake_reg <= break_wake_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_cause_reg <= `RESET_CAUSE_RESET;
        end else begin
            reset_cause_reg <= reset_cause_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            break_status_reg <= `BREAK_STATUS_RESET;
        end else begin
            break_status_reg <= break_status_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            break_flag_ctrl_reg <= `BREAK_CTRL_RESET;
        end else begin
            break_flag_ctrl_reg <= break_flag_ctrl_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= `RDATA_RESET;
        end else begin
            rdata_o <= rdata_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clear_imask_reg   <= 1'b0;
            cpu_clk_en_reg    <= 1'b1;
            periph_clk_en_reg <= 1'b1;
            clk_gen_reg       <= 1'b1;
            wdog_run_reg      <= 1'b0;
        end else begin
            clear_imask_reg   <= clear_imask_next;
            cpu_clk_en_reg    <= cpu_clk_en_next;
            periph_clk_en_reg <= periph_clk_en_next;
            clk_gen_reg       <= clk_gen_next;
            wdog_run_reg      <= wdog_run_next;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_reg       <= 1'b0;
            exit_req_reg    <= 1'b0;
            clear_allow_reg <= 1'b1;
        end else begin
            stack_reg       <= stack_next;
            exit_req_reg    <= exit_request;
            // other modules gate their clears on this level
            clear_allow_reg <= clear_allowed;
        end
    end

    assign clear_imask_o           = clear_imask_reg;
    assign cpu_clk_en_o            = cpu_clk_en_reg;
    assign periph_clk_en_o         = periph_clk_en_reg;
    assign clock_gen_output_o      = clk_gen_reg;
    assign stack_start_o           = stack_reg;
    assign lowpower_exit_request_o = exit_req_reg;
    assign watchdog_run_o          = wdog_run_reg;
    assign status_clear_allow_o    = clear_allow_reg;
endmodule

// ==== hw/lowpower_defs.svh ====
// register map, field positions, reset values and timing counts
`ifndef LOWPOWER_DEFS_SVH
`define LOWPOWER_DEFS_SVH

`define BREAK_STATUS_ADDR     16'hFE00
`define RESET_CAUSE_ADDR      16'hFE01
`define BREAK_FLAG_CTRL_ADDR  16'hFE03

`define BREAK_EXIT_BIT        1
`define BREAK_CLEAR_EN_BIT    7

`define CAUSE_POR_BIT         7
`define CAUSE_PIN_BIT         6
`define CAUSE_WDOG_BIT        5
`define CAUSE_OPCODE_BIT      4
`define CAUSE_ADDR_BIT        3
`define CAUSE_MONITOR_BIT     2
`define CAUSE_LVI_BIT         1

`define RESET_CAUSE_RESET     8'h80
`define BREAK_STATUS_RESET    8'h00
`define BREAK_CTRL_RESET      8'h00
`define RDATA_RESET           8'h00

`define LONG_RECOVERY_CYCLES  4096
`define SHORT_RECOVERY_CYCLES 32
`define RECOVERY_CNT_W        13

`endif

// ==== hw/lowpower_pkg.sv ====
// types shared by the low-power controller
package lowpower_pkg;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_WAIT    = 2'b01,
        ST_STOP    = 2'b10,
        ST_RECOVER = 2'b11
    } lp_state_t;

    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic watchdog;
        logic bad_opcode;
        logic bad_address;
        logic opcode_fetch;
        logic monitor_entry;
        logic vector_erased;
        logic ext_interrupt_pin_one_at_supply;
        logic low_voltage;
    } reset_src_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } reg_req_t;

endpackage

// ==== hw/recovery_counter.sv ====
// stop recovery counter, held clear during stop, counts oscillator ticks
`include "lowpower_defs.svh"

module recovery_counter #(
    parameter int W = `RECOVERY_CNT_W
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic         clear_i,
    input  wire logic         tick_i,
    input  wire logic [W-1:0] limit_i,
    output logic              done_o
);
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    wire          reached = (count_reg == limit_i);

    assign count_next = clear_i ? '0 :
                        (tick_i && !reached) ? count_reg + W'(1) : count_reg;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign done_o = reached && !clear_i;
endmodule

// ==== bench/osc_model.sv ====
// internal oscillator model: one tick every DIV bus cycles
module osc_model #(
    parameter int DIV = 2
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    output logic      osc_tick_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_reg;
    // free running, so ticks also fall inside stop
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_reg <= 0;
        else cnt_reg <= (cnt_reg == DIV - 1) ? 0 : cnt_reg + 1;
    end
    assign osc_tick_o = (cnt_reg == DIV - 1);
endmodule

// ==== bench/lowpower_ctrl_chk.sv ====
// port assertions for the low-power controller
`include "lowpower_defs.svh"
module lowpower_ctrl_chk #(
    parameter logic [12:0] LONG_RECOVERY  = 13'(`LONG_RECOVERY_CYCLES),
    parameter logic [12:0] SHORT_RECOVERY = 13'(`SHORT_RECOVERY_CYCLES)
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic osc_tick_i,
    input wire logic wait_exec_i,
    input wire logic stop_exec_i,
    input wire logic irq_req_i,
    input wire logic break_irq_i,
    input wire logic break_state_i,
    input wire logic ext_rst_pin_i,
    input wire logic watchdog_disable_i,
    input wire logic short_stop_recovery_i,
    input wire logic clear_imask_o,
    input wire logic cpu_clk_en_o,
    input wire logic periph_clk_en_o,
    input wire logic clock_gen_output_o,
    input wire logic stack_start_o,
    input wire logic lowpower_exit_request_o,
    input wire logic watchdog_run_o,
    input wire logic status_clear_allow_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] ticks_reg;
    logic [13:0] lim_w;
    // includes ticks in stop, so only a lower bound
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) ticks_reg <= 14'h0000;
        else if (clock_gen_output_o) ticks_reg <= 14'h0000;
        else if (osc_tick_i) ticks_reg <= ticks_reg + 14'h0001;
    end
    assign lim_w = {1'b0, short_stop_recovery_i ? SHORT_RECOVERY
                                                : LONG_RECOVERY};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    chk_imask_pulse: assert property (
        (wait_exec_i || stop_exec_i) && cpu_clk_en_o && $past(cpu_clk_en_o)
        |=> clear_imask_o) else $error("no mask clear after entry");
    chk_wait_periph: assert property (
        !cpu_clk_en_o && clock_gen_output_o |-> periph_clk_en_o)
        else $error("peripheral clock off in wait");
    chk_stop_gates: assert property (
        !clock_gen_output_o |-> !cpu_clk_en_o && !periph_clk_en_o)
        else $error("clocks running in stop");
    chk_exit_or: assert property (
        $past(rst_n_i) |-> lowpower_exit_request_o ==
        $past(ext_rst_pin_i || irq_req_i || break_irq_i))
        else $error("exit request mismatch");
    chk_wdog_wait: assert property (
        $past(rst_n_i) && clock_gen_output_o && $past(clock_gen_output_o)
        |-> watchdog_run_o == !$past(watchdog_disable_i))
        else $error("watchdog run mismatch");
    chk_wdog_stop: assert property (
        !clock_gen_output_o |-> !watchdog_run_o)
        else $error("watchdog running in stop");
    chk_clear_allow: assert property (
        $past(rst_n_i) && !$past(break_state_i) |-> status_clear_allow_o)
        else $error("clear blocked outside break");
    chk_wait_stack: assert property (
        $rose(irq_req_i) && !cpu_clk_en_o && clock_gen_output_o &&
        !break_irq_i && !ext_rst_pin_i |-> ##[1:3] stack_start_o)
        else $error("no stacking after wait wake");
    chk_no_early_stack: assert property (
        !clock_gen_output_o |-> !stack_start_o)
        else $error("stacking during stop");
    chk_recovery_len: assert property (
        $rose(clock_gen_output_o) |-> ticks_reg >= lim_w)
        else $error("stop recovery too short");
endmodule

// ==== bench/lowpower_ctrl_tb.sv ====
// testbench for the low-power controller
`include "lowpower_defs.svh"
module lowpower_ctrl_tb
    import lowpower_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] SRC [6] = '{10'h020, 10'h030, 10'h00E,
                                       10'h040, 10'h001, 10'h300};
    localparam logic [7:0] EXP [6] = '{8'h00, 8'h08, 8'h04,
                                       8'h10, 8'h02, 8'h80};
    logic mclk_i, rst_n_i, osc_tick_i, wait_exec_i, stop_exec_i;
    logic irq_req_i, break_irq_i, break_state_i, ext_rst_pin_i;
    logic watchdog_disable_i, short_stop_recovery_i, clear_imask_o;
    logic cpu_clk_en_o, periph_clk_en_o, clock_gen_output_o;
    logic stack_start_o, lowpower_exit_request_o, watchdog_run_o;
    logic status_clear_allow_o;
    logic [7:0] rdata_o;
    reset_src_t reset_src_i;
    reg_req_t   reg_req_i;
    int         n_errors, n_checks, cyc;
    lowpower_ctrl #(.LONG_RECOVERY(13'h0040)) lowpower_ctrl_inst (
        .mclk_i, .rst_n_i, .osc_tick_i, .wait_exec_i, .stop_exec_i,
        .irq_req_i, .break_irq_i, .break_state_i, .ext_rst_pin_i,
        .watchdog_disable_i, .short_stop_recovery_i, .reset_src_i,
        .reg_req_i, .rdata_o, .clear_imask_o, .cpu_clk_en_o,
        .periph_clk_en_o, .clock_gen_output_o, .stack_start_o,
        .lowpower_exit_request_o, .watchdog_run_o, .status_clear_allow_o);
    osc_model #(.DIV(2)) osc_model_inst (
        .mclk_i, .rst_n_i, .osc_tick_o(osc_tick_i));
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // generous ceiling, the whole run needs about 450 cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run timed out", $time);
            end_of_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        n_checks++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic rw(input logic [15:0] a, input logic w,
                      input logic [7:0] d, input logic [7:0] want);
        @(negedge mclk_i) reg_req_i = '{a, !w, w, d};
        @(negedge mclk_i) reg_req_i = '0;
        if (!w) chk(rdata_o, want);
    endtask
    task automatic cause(input logic [9:0] s);
        @(negedge mclk_i) reset_src_i = s;
        @(negedge mclk_i) reset_src_i = '0;
    endtask
    // src is {pin, break, irq}; n counts cycles until the cpu runs
    task automatic lp(input logic stop, input logic [2:0] src,
                      input int lo, input int hi);
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        @(negedge mclk_i) {stop_exec_i, wait_exec_i} = {stop, !stop};
        @(negedge mclk_i) {stop_exec_i, wait_exec_i} = 2'b00;
        repeat (3) @(negedge mclk_i);
        chk(cpu_clk_en_o, 8'h00);
        chk(periph_clk_en_o, !stop);
        chk(clock_gen_output_o, !stop);
        chk(watchdog_run_o, !stop);
        {ext_rst_pin_i, break_irq_i, irq_req_i} = src;
        while (cpu_clk_en_o !== 1'b1 && n < 400) begin
            @(negedge mclk_i) n++;
            seen |= (stack_start_o === 1'b1);
        end
        {ext_rst_pin_i, break_irq_i, irq_req_i} = 3'b000;
        repeat (3) @(negedge mclk_i) seen |= (stack_start_o === 1'b1);
        chk(n >= lo && n <= hi, 8'h01);
        chk(seen, src == 3'b001);
    endtask
    initial begin
        {wait_exec_i, stop_exec_i, irq_req_i, break_irq_i} = 4'h0;
        {break_state_i, ext_rst_pin_i, watchdog_disable_i} = 3'b000;
        short_stop_recovery_i = 1'b0;
        reset_src_i = '0;
        reg_req_i = '0;
        rst_n_i = 1'b0;
        n_errors = 0;
        n_checks = 0;
        cyc = 0;
        repeat (10) @(negedge mclk_i);
        rst_n_i = 1'b1;
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h80);
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h00);
        rw(16'hFE02, 1'b0, 8'h00, 8'h00);
        cause(10'h100);
        cause(10'h080);
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h60);
        for (int i = 0; i < 6; i++) begin
            cause(SRC[i]);
            rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, EXP[i]);
        end
        lp(1'b0, 3'b001, 1, 3);
        lp(1'b0, 3'b100, 1, 3);
        lp(1'b0, 3'b010, 1, 3);
        rw(`BREAK_STATUS_ADDR, 1'b0, 8'h00, 8'h02);
        rw(`BREAK_STATUS_ADDR, 1'b1, 8'hFF, 8'h00);
        rw(`BREAK_STATUS_ADDR, 1'b0, 8'h00, 8'h02);
        rw(`BREAK_STATUS_ADDR, 1'b1, 8'h00, 8'h00);
        rw(`BREAK_STATUS_ADDR, 1'b0, 8'h00, 8'h00);
        watchdog_disable_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk(watchdog_run_o, 8'h00);
        watchdog_disable_i = 1'b0;
        short_stop_recovery_i = 1'b1;
        lp(1'b1, 3'b001, 60, 74);
        short_stop_recovery_i = 1'b0;
        lp(1'b1, 3'b001, 124, 138);
        lp(1'b1, 3'b010, 124, 138);
        rw(`BREAK_STATUS_ADDR, 1'b0, 8'h00, 8'h02);
        break_state_i = 1'b1;
        cause(10'h100);
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h40);
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h40);
        chk(status_clear_allow_o, 8'h00);
        rw(`BREAK_FLAG_CTRL_ADDR, 1'b1, 8'h80, 8'h00);
        rw(`BREAK_FLAG_CTRL_ADDR, 1'b0, 8'h00, 8'h80);
        chk(status_clear_allow_o, 8'h01);
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h40);
        break_state_i = 1'b0;
        rw(`RESET_CAUSE_ADDR, 1'b0, 8'h00, 8'h00);
        end_of_test();
    end
endmodule
bind lowpower_ctrl lowpower_ctrl_chk #(
    .LONG_RECOVERY(LONG_RECOVERY), .SHORT_RECOVERY(SHORT_RECOVERY)
) lowpower_ctrl_chk_inst (.*);
